// ==== bench/mid_core_model.sv ====
// Core-side model that times each decoded instruction.
// Assumes issue, busy and dead_cycle come from the decoder on pclk.
`timescale 1ns/100ps

module mid_core_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic issue, // first cycle of an instruction
	input wire logic busy, // instruction in progress
	input wire logic dead_cycle, // cycle runs as no-operation
	output logic [1:0] len_r, // busy cycles of the last instruction
	output logic [1:0] dead_r // dead cycles of the last instruction
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_r <= 2'h0;
			dead_r <= 2'h0;
		end else if (issue) begin
			len_r <= 2'h1;
			dead_r <= {1'b0, dead_cycle};
		end else begin
			len_r <= len_r + {1'b0, busy};
			dead_r <= dead_r + {1'b0, dead_cycle};
		end
	end
endmodule

// ==== bench/mid_decoder_tb.sv ====
// Self-checking bench for the decoder, driven over APB.
// Assumes the decoder answers with zero wait states as its note says.
`timescale 1ns/100ps

module mid_decoder_tb;
	import mid_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic issue, busy, dead_cycle, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] len_r, dead_r;
	mid_dec_t dec;
	int miscompares, cmp_count;
	// Row: {word, cond, cycles, flag mask, op index}.
	logic [27:0] rows [36] = '{
		{14'h0b05,2'h0,2'h1,4'h0,6'h01}, {14'h0b05,2'h1,2'h2,4'h0,6'h01},
		{14'h0f05,2'h1,2'h2,4'h0,6'h02}, {14'h0f05,2'h0,2'h1,4'h0,6'h02},
		{14'h1005,2'h0,2'h1,4'h0,6'h03}, {14'h1405,2'h0,2'h1,4'h0,6'h04},
		{14'h1805,2'h0,2'h2,4'h0,6'h05}, {14'h1805,2'h2,2'h1,4'h0,6'h05},
		{14'h1c05,2'h2,2'h2,4'h0,6'h06}, {14'h1c05,2'h0,2'h1,4'h0,6'h06},
		{14'h3e12,2'h0,2'h1,4'he,6'h07}, {14'h3c12,2'h0,2'h1,4'he,6'h08},
		{14'h3912,2'h0,2'h1,4'h2,6'h09}, {14'h3812,2'h0,2'h1,4'h2,6'h0a},
		{14'h3a12,2'h0,2'h1,4'h2,6'h0b}, {14'h3012,2'h0,2'h1,4'h0,6'h0c},
		{14'h0025,2'h0,2'h1,4'h0,6'h0d}, {14'h3185,2'h0,2'h1,4'h0,6'h0e},
		{14'h3212,2'h0,2'h2,4'h0,6'h0f}, {14'h000b,2'h0,2'h2,4'h0,6'h10},
		{14'h2012,2'h0,2'h2,4'h0,6'h11}, {14'h000a,2'h0,2'h2,4'h0,6'h12},
		{14'h2812,2'h0,2'h2,4'h0,6'h13}, {14'h0009,2'h0,2'h2,4'h0,6'h14},
		{14'h0008,2'h0,2'h2,4'h0,6'h15}, {14'h3412,2'h0,2'h2,4'h0,6'h16},
		{14'h0064,2'h0,2'h1,4'h1,6'h17}, {14'h0063,2'h0,2'h1,4'h1,6'h18},
		{14'h0001,2'h0,2'h1,4'h0,6'h19}, {14'h0062,2'h0,2'h1,4'h0,6'h1a},
		{14'h0065,2'h0,2'h1,4'h0,6'h1b}, {14'h3105,2'h0,2'h1,4'h0,6'h1c},
		{14'h3f05,2'h0,2'h1,4'h2,6'h1f}, {14'h3f85,2'h0,2'h1,4'h0,6'h20},
		{14'h0010,2'h0,2'h1,4'h2,6'h1d}, {14'h3b00,2'h0,2'h1,4'h0,6'h00}
	};

	mid_decoder i_mid_decoder (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dec(dec), .issue(issue),
		.busy(busy), .dead_cycle(dead_cycle)
	);

	mid_core_model i_mid_core_model (
		.pclk(pclk), .presetn(presetn), .issue(issue), .busy(busy),
		.dead_cycle(dead_cycle), .len_r(len_r), .dead_r(dead_r)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next call never drives psel twice in one step.
		@(posedge pclk);
	endtask

	// A new word is only taken once busy has dropped.
	task automatic run(input logic [13:0] w, input logic [1:0] c);
		apb(1'b1, ADDR_COND, {30'h0, c});
		apb(1'b1, ADDR_INSTR, {18'h0, w});
		do @(posedge pclk); while (busy !== 1'b0);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_DECODE, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			run(rows[i][27:14], rows[i][13:12]);
			apb(1'b0, ADDR_DECODE, 32'h0);
			chk({20'h0, rd[11:0]}, {20'h0, rows[i][11:0]});
			chk({26'h0, dec.op}, {26'h0, rows[i][5:0]});
			chk({28'h0, len_r, dead_r}, {28'h0, rows[i][11:10], rows[i][11:10] - 2'h1});
		end
		apb(1'b0, ADDR_INSTR, 32'h0);
		chk(rd, 32'h00003b00);
		apb(1'b0, 8'h1c, 32'h0);
		chk({rd[30:0], e}, 32'h1);
		run(14'h0001, 2'h0);
		run(14'h313f, 2'h0);
		apb(1'b0, ADDR_PTR, 32'h0);
		chk(rd, 32'h0000ffff);
		run(14'h0b00, 2'h1);
		chk({28'h0, len_r, dead_r}, 32'h0000000e);
		run(14'h0010, 2'h0);
		apb(1'b0, ADDR_DECODE, 32'h0);
		chk({30'h0, rd[11:10]}, 32'h2);
		apb(1'b0, ADDR_IADDR, 32'h0);
		chk(rd, 32'h0);
		run(14'h001d, 2'h0);
		apb(1'b0, ADDR_IADDR, 32'h0);
		chk(rd, 32'h0000ffff);
		apb(1'b0, ADDR_PTR, 32'h0);
		chk(rd, 32'hffff0000);
		run(14'h003f, 2'h0);
		run(14'h31ff, 2'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000fff0);
		run(14'h0bff, 2'h0);
		apb(1'b0, ADDR_FIELDS, 32'h0);
		chk(rd & 32'h0000047f, 32'h0000047f);
		run(14'h1785, 2'h0);
		apb(1'b0, ADDR_FIELDS, 32'h0);
		chk(rd & 32'h000007ff, 32'h00000385);
		// A reset between instructions, with the decoder idle, must clear the bank and pc-high loads made above.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h00000000);
		stop_test();
	end
endmodule

// ==== inc/mid_pkg.sv ====
// Constants and types shared by the instruction decoder.
// Assumes a single APB clock domain and 14-bit instruction words.
package mid_pkg;

	// Register byte addresses on the APB port.
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_COND = 8'h04;
	localparam logic [7:0] ADDR_DECODE = 8'h08;
	localparam logic [7:0] ADDR_FIELDS = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_PTR = 8'h14;
	localparam logic [7:0] ADDR_IADDR = 8'h18;

	// Bit positions in the condition register.
	localparam int COND_ZERO = 0;
	localparam int COND_TBIT = 1;

	// Written-flag masks, ordered {carry, digit carry, zero, timeout/power-down}.
	localparam logic [3:0] FM_NONE = 4'h0;
	localparam logic [3:0] FM_ZERO = 4'h2;
	localparam logic [3:0] FM_ARITH = 4'he;
	localparam logic [3:0] FM_POWER = 4'h1;

	// Cycle counts.
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// Reset values of the architectural state held here.
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [4:0] BANK_RST = 5'h00;
	localparam logic [6:0] PCH_RST = 7'h00;

	typedef enum logic [5:0] {
		OP_NO_OPERATION, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
		OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_SKIP_CLEAR, OP_TEST_SKIP_SET,
		OP_ADD_LITERAL, OP_SUB_LITERAL, OP_AND_LITERAL, OP_OR_LITERAL,
		OP_XOR_LITERAL, OP_LOAD_LITERAL, OP_BANK_SELECT_LOAD,
		OP_PC_HIGH_LOAD, OP_RELATIVE_BRANCH, OP_RELATIVE_BRANCH_BY_ACC,
		OP_SUB_CALL, OP_CALL_BY_ACC, OP_JUMP, OP_INTERRUPT_RETURN,
		OP_SUB_RETURN, OP_RETURN_WITH_LITERAL, OP_WATCHDOG_CLEAR,
		OP_STANDBY, OP_SOFT_RESET, OP_OPTION_LOAD, OP_DIRECTION_LOAD,
		OP_POINTER_ADD, OP_INDIRECT_LOAD, OP_INDIRECT_STORE,
		OP_INDEXED_LOAD, OP_INDEXED_STORE
	} mid_op_t;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_TAIL} mid_seq_t;

	typedef struct packed {
		logic [13:0] word;
		mid_op_t op;
		logic [6:0] faddr;
		logic [2:0] bsel;
		logic dest;
		logic [10:0] lit;
		logic pn;
		logic [1:0] mm;
		logic [3:0] fmask;
		logic pc_change;
		logic skip_taken;
		logic ind_extra;
		logic [1:0] cycles;
		logic [15:0] pnew;
		logic [15:0] iaddr;
	} mid_dec_t;

	typedef struct packed {
		mid_seq_t seq;
		logic [1:0] left;
		logic issue;
		mid_dec_t dec;
		logic [1:0] cond;
		logic [1:0][15:0] ptr;
		logic [4:0] bank;
		logic [6:0] pch;
		logic [31:0] rdata;
		logic slverr;
	} mid_state_t;

endpackage

// ==== verilog/mid_decoder.sv ====
// Instruction decoder with APB register access and a cycle sequencer.
// Assumes the datapath reports skip conditions through the condition register
// before the word is written, and a zero-wait APB master on pclk.
//
// Contract
// - decrement-skip-zero, one cycle or two on skip
// - increment-skip-zero, extra cycle when result zero
// - bit clear/set, three-bit select, no flags
// - test-skip-clear, skip when selected bit clear
// - test-skip-set, skip when selected bit set
// - and/or/xor literal, zero flag only
// - add/subtract literal, carry digit zero flags
// - literal loads to accumulator or pc latch
// - bank select load of five-bit immediate
// - relative branches by literal or accumulator, two cycles
// - call, jump, accumulator call take two cycles
// - three return forms take two cycles
// - watchdog clear and standby write power flags
// - no-op, soft reset, option load, one cycle
// - direction load selected by three-bit field
// - pointer add of six-bit literal, one cycle
// - signed literal, sixteen-bit pointer wraps around
// - indexed indirect load and store via pointer
// - indirect load/store with pre/post increment/decrement
// - pc change or true skip: second cycle dead
// - indirect access with pointer msb adds cycle
// - destination bit selects accumulator or file
`timescale 1ns/100ps

module mid_decoder
	import mid_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, high for write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped address
	output mid_dec_t dec, // decoded instruction
	output logic issue, // one-cycle pulse on first execution cycle
	output logic busy, // instruction cycles in progress
	output logic dead_cycle // current cycle executes as no-operation
);

	mid_state_t r;
	mid_state_t n;
	mid_dec_t dn;
	logic acc_wr;
	logic start;
	logic hit;
	logic [31:0] rd_mux;

	function automatic mid_dec_t decode(
		input logic [13:0] w,
		input logic [1:0] c,
		input logic [1:0][15:0] p
	);
		mid_dec_t d;
		logic ind;
		logic fileop;
		logic [15:0] step;
		logic [15:0] off;
		d = '0;
		d.word = w;
		d.op = OP_NO_OPERATION;
		d.faddr = w[6:0];
		d.bsel = w[9:7];
		d.dest = w[7];
		d.lit = w[10:0];
		d.mm = w[1:0];
		d.fmask = FM_NONE;
		ind = 1'b0;
		fileop = 1'b0;
		off = {{10{w[5]}}, w[5:0]};
		case (w[13:12])
			2'b00: begin
				if (w[11:8] == 4'hb) begin
					d.op = OP_DEC_SKIP_ZERO;
					fileop = 1'b1;
					d.skip_taken = c[COND_ZERO];
				end else if (w[11:8] == 4'hf) begin
					d.op = OP_INC_SKIP_ZERO;
					fileop = 1'b1;
					d.skip_taken = c[COND_ZERO];
				end else if (w[11:8] == 4'h0) begin
					case (w[7:0])
						8'h00: d.op = OP_NO_OPERATION;
						8'h01: d.op = OP_SOFT_RESET;
						8'h62: d.op = OP_OPTION_LOAD;
						8'h08: d.op = OP_SUB_RETURN;
						8'h09: d.op = OP_INTERRUPT_RETURN;
						8'h0a: d.op = OP_CALL_BY_ACC;
						8'h0b: d.op = OP_RELATIVE_BRANCH_BY_ACC;
						8'h63: begin
							d.op = OP_STANDBY;
							d.fmask = FM_POWER;
						end
						8'h64: begin
							d.op = OP_WATCHDOG_CLEAR;
							d.fmask = FM_POWER;
						end
						default: begin
							if (w[7:3] == 5'h0c) begin
								d.op = OP_DIRECTION_LOAD;
								d.lit = {8'h00, w[2:0]};
							end else if (w[7:5] == 3'h1) begin
								d.op = OP_BANK_SELECT_LOAD;
								d.lit = {6'h00, w[4:0]};
							end else if (w[7:4] == 4'h1) begin
								d.op = w[3] ? OP_INDIRECT_STORE : OP_INDIRECT_LOAD;
								d.fmask = w[3] ? FM_NONE : FM_ZERO;
								d.pn = w[2];
								ind = p[w[2]][15];
							end
						end
					endcase
				end
			end
			2'b01: begin
				fileop = 1'b1;
				case (w[11:10])
					2'b00: d.op = OP_BIT_CLEAR;
					2'b01: d.op = OP_BIT_SET;
					2'b10: begin
						d.op = OP_TEST_SKIP_CLEAR;
						d.skip_taken = ~c[COND_TBIT];
					end
					default: begin
						d.op = OP_TEST_SKIP_SET;
						d.skip_taken = c[COND_TBIT];
					end
				endcase
			end
			2'b10: begin
				d.op = w[11] ? OP_JUMP : OP_SUB_CALL;
			end
			default: begin
				case (w[11:8])
					4'h0: d.op = OP_LOAD_LITERAL;
					4'h1: begin
						if (w[7]) begin
							d.op = OP_PC_HIGH_LOAD;
							d.lit = {4'h0, w[6:0]};
						end else begin
							d.op = OP_POINTER_ADD;
							d.pn = w[6];
						end
					end
					4'h2, 4'h3: d.op = OP_RELATIVE_BRANCH;
					4'h4: d.op = OP_RETURN_WITH_LITERAL;
					4'h8: begin
						d.op = OP_OR_LITERAL;
						d.fmask = FM_ZERO;
					end
					4'h9: begin
						d.op = OP_AND_LITERAL;
						d.fmask = FM_ZERO;
					end
					4'ha: begin
						d.op = OP_XOR_LITERAL;
						d.fmask = FM_ZERO;
					end
					4'hc: begin
						d.op = OP_SUB_LITERAL;
						d.fmask = FM_ARITH;
					end
					4'he: begin
						d.op = OP_ADD_LITERAL;
						d.fmask = FM_ARITH;
					end
					4'hf: begin
						d.op = w[7] ? OP_INDEXED_STORE : OP_INDEXED_LOAD;
						d.fmask = w[7] ? FM_NONE : FM_ZERO;
						d.pn = w[6];
						ind = p[w[6]][15];
					end
					default: d.op = OP_NO_OPERATION;
				endcase
			end
		endcase
		// destination only for byte file ops
		if (d.op != OP_DEC_SKIP_ZERO && d.op != OP_INC_SKIP_ZERO) begin
			d.dest = 1'b0;
		end
		// file address 0 or 1 reaches through a pointer
		if (fileop && d.faddr[6:1] == 6'h00) begin
			ind = p[d.faddr[0]][15];
		end
		d.ind_extra = ind;
		d.pc_change = (d.op inside {OP_RELATIVE_BRANCH, OP_RELATIVE_BRANCH_BY_ACC,
			OP_SUB_CALL, OP_CALL_BY_ACC, OP_JUMP, OP_INTERRUPT_RETURN,
			OP_SUB_RETURN, OP_RETURN_WITH_LITERAL});
		// one extra cycle for pc change or taken skip, one more for pointer msb
		d.cycles = CYC_ONE + {1'b0, d.pc_change | d.skip_taken} + {1'b0, ind};
		step = d.mm[0] ? 16'hffff : 16'h0001;
		d.pnew = p[d.pn];
		d.iaddr = p[d.pn];
		case (d.op)
			OP_POINTER_ADD: d.pnew = p[d.pn] + off;
			OP_INDEXED_LOAD, OP_INDEXED_STORE: d.iaddr = p[d.pn] + off;
			OP_INDIRECT_LOAD, OP_INDIRECT_STORE: begin
				d.pnew = p[d.pn] + step;
				d.iaddr = d.mm[1] ? p[d.pn] : d.pnew;
			end
			default: d.pnew = p[d.pn];
		endcase
		return d;
	endfunction

	assign acc_wr = psel & penable & pwrite;
	assign start = acc_wr & (paddr == ADDR_INSTR) & (r.seq == SEQ_IDLE);
	assign dn = decode(pwdata[13:0], r.cond, r.ptr);

	always_comb begin
		hit = 1'b1;
		case (paddr)
			ADDR_INSTR: rd_mux = {18'h0, r.dec.word};
			ADDR_COND: rd_mux = {30'h0, r.cond};
			ADDR_DECODE: rd_mux = {17'h0, r.dec.ind_extra, r.dec.skip_taken,
				r.dec.pc_change, r.dec.cycles, r.dec.fmask, r.dec.op};
			ADDR_FIELDS: rd_mux = {7'h0, r.dec.lit, r.dec.mm, r.dec.pn,
				r.dec.dest, r.dec.bsel, r.dec.faddr};
			ADDR_STATUS: rd_mux = {16'h0, r.pch, r.bank, r.left,
				r.seq == SEQ_TAIL, r.seq != SEQ_IDLE};
			ADDR_PTR: rd_mux = {r.ptr[1], r.ptr[0]};
			ADDR_IADDR: rd_mux = {16'h0, r.dec.iaddr};
			default: begin
				rd_mux = 32'h0;
				hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		n = r;
		n.issue = 1'b0;
		case (r.seq)
			SEQ_IDLE: n.seq = SEQ_IDLE;
			SEQ_FIRST, SEQ_TAIL: begin
				if (r.left == 2'h0) begin
					n.seq = SEQ_IDLE;
				end else begin
					n.seq = SEQ_TAIL;
					n.left = r.left - 2'h1;
				end
			end
			default: n.seq = SEQ_IDLE;
		endcase
		// A word written while busy is dropped so the cycle count stays exact.
		if (start) begin
			n.dec = dn;
			n.issue = 1'b1;
			n.seq = SEQ_FIRST;
			n.left = dn.cycles - 2'h1;
			if (dn.op inside {OP_POINTER_ADD, OP_INDIRECT_LOAD, OP_INDIRECT_STORE}) begin
				n.ptr[dn.pn] = dn.pnew;
			end
			if (dn.op == OP_BANK_SELECT_LOAD) begin
				n.bank = dn.lit[4:0];
			end
			if (dn.op == OP_PC_HIGH_LOAD) begin
				n.pch = dn.lit[6:0];
			end
			if (dn.op == OP_SOFT_RESET) begin
				n.ptr = {PTR_RST, PTR_RST};
				n.bank = BANK_RST;
				n.pch = PCH_RST;
			end
		end
		if (acc_wr && paddr == ADDR_COND) begin
			n.cond = pwdata[1:0];
		end
		// Read data is captured in setup so it comes from a flop in access.
		if (psel && !penable) begin
			n.rdata = pwrite ? 32'h0 : rd_mux;
			n.slverr = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.rdata;
	assign pslverr = r.slverr & psel & penable;
	assign pready = 1'b1;
	assign dec = r.dec;
	assign issue = r.issue;
	assign busy = r.seq != SEQ_IDLE;
	assign dead_cycle = r.seq == SEQ_TAIL;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence run_two;
		busy [*2] ##1 !busy;
	endsequence

	sequence run_three;
		busy [*3] ##1 !busy;
	endsequence

	sequence run_one;
		busy ##1 !busy;
	endsequence

	dec_skip_a: assert property (
		issue && dec.op == OP_DEC_SKIP_ZERO && dec.skip_taken && !dec.ind_extra
		|-> run_two) else $error("decrement skip not two cycles");
	inc_skip_a: assert property (
		issue && dec.op == OP_INC_SKIP_ZERO && !dec.skip_taken && !dec.ind_extra
		|-> run_one) else $error("increment without skip not one cycle");
	bit_flags_a: assert property (
		issue && dec.op inside {OP_BIT_CLEAR, OP_BIT_SET}
		|-> dec.fmask == 4'h0 && !dec.pc_change) else $error("bit op writes flags");
	test_clear_a: assert property (
		issue && dec.op == OP_TEST_SKIP_CLEAR && dec.skip_taken && !dec.ind_extra
		|=> dead_cycle ##1 !busy) else $error("test clear skip wrong");
	test_set_a: assert property (
		issue && dec.op == OP_TEST_SKIP_SET && !dec.skip_taken && !dec.ind_extra
		|-> run_one) else $error("test set without skip wrong");
	logic_zero_a: assert property (
		issue && dec.word[13:8] inside {6'h38, 6'h39, 6'h3a}
		|-> dec.fmask == 4'h2) else $error("logic literal flags wrong");
	arith_flags_a: assert property (
		issue && dec.word[13:8] inside {6'h3c, 6'h3e}
		|-> dec.fmask == 4'he) else $error("arith literal flags wrong");
	bank_load_a: assert property (
		issue && dec.op == OP_BANK_SELECT_LOAD
		|-> r.bank == dec.word[4:0] && dec.fmask == 4'h0) else $error("bank load wrong");
	branch_two_a: assert property (
		issue && dec.pc_change && !dec.ind_extra
		|-> run_two) else $error("branch not two cycles");
	power_flags_a: assert property (
		issue && dec.word inside {14'h0063, 14'h0064}
		|-> dec.fmask == 4'h1 && dec.cycles == 2'h1) else $error("power op wrong");
	ptr_step_a: assert property (
		issue && dec.op == OP_INDIRECT_LOAD && dec.mm == 2'h0
		|-> r.ptr[dec.pn] == dec.iaddr) else $error("pre-increment address wrong");
	tail_dead_a: assert property (
		issue && dec.cycles != 2'h1 |=> dead_cycle) else $error("second cycle not dead");
	ind_extra_a: assert property (
		issue && dec.cycles == 2'h3 |-> run_three) else $error("three-cycle run wrong");
	dest_bit_a: assert property (
		issue && dec.op == OP_DEC_SKIP_ZERO |-> dec.dest == dec.word[7])
		else $error("destination bit lost");
	unlisted_a: assert property (
		issue && dec.word[13:8] inside {6'h35, 6'h3b, 6'h3d}
		|-> dec.op == OP_NO_OPERATION) else $error("unlisted word not no-op");

endmodule
